// ==== rcsf_alu_flags.sv ====
// module: combinational flag generator for add, subtract, logic and rotate
`timescale 1ns/1ps
`default_nettype none
module rcsf_alu_flags (
  input  wire logic                    start,     // run one operation
  input  wire rcsf_pkg::rcsf_aluop_type op,       // operation code
  input  wire logic [7:0]              opA,       // first operand / rotate source
  input  wire logic [7:0]              opB,       // second operand
  input  wire logic                    carryIn,   // current carry for rotates
  rcsf_flag_if.src                     flags      // computed result and flags
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] bNeg;
  always_comb
  begin
    // subtract adds the inverted operand plus a carry-in of one, so carries mean "no borrow";
    // folding the +1 into the operand would lose the carry when subtracting zero
    bNeg = (op == rcsf_pkg::ALU_SUB) ? ~opB : opB;
    sum  = {1'b0, opA} + {1'b0, bNeg} + {8'h00, op == rcsf_pkg::ALU_SUB};
    low  = {1'b0, opA[3:0]} + {1'b0, bNeg[3:0]} + {4'h0, op == rcsf_pkg::ALU_SUB};
    flags.valid       = start;
    flags.setZ        = 1'b1;
    flags.setDc       = 1'b0;
    flags.setC        = 1'b0;
    flags.nibbleCarry = low[4];
    flags.carry       = sum[8];
    flags.result      = sum[7:0];
    case (op)
      rcsf_pkg::ALU_ADD, rcsf_pkg::ALU_SUB:
      begin
        flags.setDc = 1'b1;
        flags.setC  = 1'b1;
      end
      rcsf_pkg::ALU_AND:
        flags.result = opA & opB;
      rcsf_pkg::ALU_RRF:
      begin
        flags.result = {carryIn, opA[7:1]};
        flags.carry  = opA[0];
        flags.setC   = 1'b1;
        flags.setZ   = 1'b0;
      end
      rcsf_pkg::ALU_RLF:
      begin
        flags.result = {opA[6:0], carryIn};
        flags.carry  = opA[7];
        flags.setC   = 1'b1;
        flags.setZ   = 1'b0;
      end
      default:
        flags.setZ = 1'b0;
    endcase
    flags.zero = (flags.result == 8'h00);
  end
endmodule : rcsf_alu_flags
`default_nettype wire

// ==== rcsf_event_decode.sv ====
// module: one-hot reset/wake request lines reduced to a single event code
`timescale 1ns/1ps
`default_nettype none
module rcsf_event_decode (
  input  wire logic                 porReq,       // power-on
  input  wire logic                 borReq,       // brown-out
  input  wire logic                 wdtReq,       // watchdog timeout
  input  wire logic                 extReq,       // external reset pin
  input  wire logic                 swReq,        // reset instruction
  input  wire logic                 ovfReq,       // stack overflow
  input  wire logic                 unfReq,       // stack underflow
  input  wire logic                 irqWakeReq,   // interrupt while asleep
  input  wire logic                 asleep,       // core is sleeping
  input  wire logic                 faultEnable,  // stack-fault reset enable
  output rcsf_pkg::rcsf_event_type  eventCode     // winning event
);
  // fixed priority: supply events first, then pin, watchdog, software
  always_comb
  begin
    if (porReq)
      eventCode = rcsf_pkg::EV_POR;
    else if (borReq)
      eventCode = rcsf_pkg::EV_BOR;
    else if (extReq)
      eventCode = rcsf_pkg::EV_EXT;
    else if (wdtReq)
      eventCode = asleep ? rcsf_pkg::EV_WDTWK : rcsf_pkg::EV_WDT;
    else if (irqWakeReq && asleep)
      eventCode = rcsf_pkg::EV_IRQWK;
    else if (swReq)
      eventCode = rcsf_pkg::EV_SW;
    else if (ovfReq && faultEnable)
      eventCode = rcsf_pkg::EV_OVF;
    else if (unfReq && faultEnable)
      eventCode = rcsf_pkg::EV_UNF;
    else
      eventCode = rcsf_pkg::EV_NONE;
  end
endmodule : rcsf_event_decode
`default_nettype wire

// ==== rcsf_flag_if.sv ====
// interface: flag results from the arithmetic unit to the register block
`timescale 1ns/1ps
`default_nettype none
interface rcsf_flag_if;
  logic       valid;
  logic [7:0] result;
  logic       zero;
  logic       nibbleCarry;
  logic       carry;
  logic       setZ;
  logic       setDc;
  logic       setC;
  modport src (output valid, result, zero, nibbleCarry, carry, setZ, setDc, setC);
  modport dst (input valid, result, zero, nibbleCarry, carry, setZ, setDc, setC);
endinterface : rcsf_flag_if
`default_nettype wire

// ==== rcsf_pkg.sv ====
// package: register map, reset values and event codes of the reset-cause block
package rcsf_pkg;
  localparam logic [7:0] STATUS_ADDR  = 8'h00;
  localparam logic [7:0] PWRCTL_ADDR  = 8'h04;
  localparam logic [7:0] IRQST_ADDR   = 8'h08;
  localparam logic [7:0] IRQMASK_ADDR = 8'h0c;
  localparam logic [7:0] CTRL_ADDR    = 8'h10;
  localparam logic [7:0] PC_ADDR      = 8'h14;
  localparam logic [7:0] ALU_ADDR     = 8'h18;
  localparam logic [7:0] ALURES_ADDR  = 8'h1c;
  // status bit positions
  localparam int STAT_TO = 4;
  localparam int STAT_PD = 3;
  localparam int STAT_Z  = 2;
  localparam int STAT_DC = 1;
  localparam int STAT_C  = 0;
  // power-control bit positions
  localparam int PC_OVF = 7;
  localparam int PC_UNF = 6;
  localparam int PC_EXT = 3;
  localparam int PC_SW  = 2;
  localparam int PC_POR = 1;
  localparam int PC_BOR = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] PWRCTL_POR = 8'h0c;
  localparam logic [7:0] PWRCTL_IMPL = 8'hcf;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] IRQ_VEC   = 13'h0004;
  // interrupt status bits, one per event kind except underflow, which shares bit 0 with power-on
  localparam int IRQ_W = 8;
  typedef enum logic [3:0] {
    EV_NONE  = 4'h0,
    EV_POR   = 4'h1,
    EV_BOR   = 4'h2,
    EV_WDT   = 4'h3,
    EV_WDTWK = 4'h4,
    EV_IRQWK = 4'h5,
    EV_EXT   = 4'h6,
    EV_SW    = 4'h7,
    EV_OVF   = 4'h8,
    EV_UNF   = 4'h9
  } rcsf_event_type;
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_RRF = 3'h3,
    ALU_RLF = 3'h4
  } rcsf_aluop_type;
endpackage : rcsf_pkg

// ==== rcsf_reset_cause.sv ====
// module: reset-cause and status flags with a classic Wishbone register port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - every reset or wake event updates status or power-control cause flags
// - power-on sets timeout and power-down, pc to zero, power-control pattern
// - brown-out clears brown-out flag, sets TO PD pin soft, clears stack flags
// - watchdog reset clears timeout flag only, restarts at zero
// - watchdog wake clears timeout and power-down, continues at pc plus one
// - interrupt wake sets timeout, clears power-down, continues at pc plus one
// - interrupt wake with global enable runs next op then vectors
// - pin reset while running clears pin flag, restarts at zero
// - pin reset while asleep clears pin flag, sets timeout, clears power-down
// - reset instruction clears soft-reset flag, restarts at zero
// - enabled stack overflow resets and sets overflow flag
// - enabled stack underflow resets and sets underflow flag
// - unimplemented status and power-control bits read zero
// - zero flag follows whether an add, subtract or AND result is zero
// - nibble carry flag shows carry out of bit three
// - subtract adds two's complement so carries act as inverted borrow
// - rotates load carry from the bit shifted out
module rcsf_reset_cause (
  input  wire logic        ref_clk,         // 200 MHz core clock
  input  wire logic        reset_n,         // async reset, active low
  input  wire logic        wb_cyc_i,        // wishbone cycle
  input  wire logic        wb_stb_i,        // wishbone strobe
  input  wire logic        wb_we_i,         // wishbone write
  input  wire logic [7:0]  wb_adr_i,        // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,        // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,        // wishbone write data
  output logic [31:0]      wb_dat_o,        // wishbone read data
  output logic             wb_ack_o,        // wishbone acknowledge
  input  wire logic        porReq,          // power-on event
  input  wire logic        borReq,          // brown-out event
  input  wire logic        wdtReq,          // watchdog timeout
  input  wire logic        extReq,          // external reset pin event
  input  wire logic        swReq,           // reset instruction executed
  input  wire logic        ovfReq,          // stack overflow
  input  wire logic        unfReq,          // stack underflow
  input  wire logic        irqWakeReq,      // interrupt pending
  input  wire logic        sleepReq,        // sleep instruction
  input  wire logic        watchdogClear,   // watchdog clear instruction
  input  wire logic        globalIrqEnable, // global interrupt enable
  input  wire logic [12:0] pcCurrent,       // current program counter
  output logic [12:0]      pcLoad,          // program counter to load
  output logic             pcLoadValid,     // one-cycle pc load pulse
  output logic             pushReturn,      // push pcLoad-return and vector
  output logic             asleep,          // core sleeping
  output logic             irq              // unmasked event pending
);
  rcsf_flag_if aluBus ();
  rcsf_pkg::rcsf_event_type eventCode;

  typedef struct packed {
    logic [7:0]              status;
    logic [7:0]              pwrctl;
    logic [rcsf_pkg::IRQ_W-1:0] irqStatus;
    logic [rcsf_pkg::IRQ_W-1:0] irqMask;
    logic                    faultEnable;
    logic [12:0]             pcLoad;
    logic                    pcLoadValid;
    logic                    pushReturn;
    logic                    vectorPending;
    logic                    asleep;
    logic [7:0]              aluA;
    logic [7:0]              aluB;
    logic [7:0]              aluResult;
    rcsf_pkg::rcsf_aluop_type aluOp;
    logic                    aluStart;
    logic [31:0]             rdata;
    logic                    ack;
    logic                    irq;
  } rcsf_state_type;

  rcsf_state_type state_q;
  rcsf_state_type state_d;

  rcsf_event_decode u_decode (
    .porReq      (porReq),
    .borReq      (borReq),
    .wdtReq      (wdtReq),
    .extReq      (extReq),
    .swReq       (swReq),
    .ovfReq      (ovfReq),
    .unfReq      (unfReq),
    .irqWakeReq  (irqWakeReq),
    .asleep      (state_q.asleep),
    .faultEnable (state_q.faultEnable),
    .eventCode   (eventCode)
  );

  rcsf_alu_flags u_alu (
    .start   (state_q.aluStart),
    .op      (state_q.aluOp),
    .opA     (state_q.aluA),
    .opB     (state_q.aluB),
    .carryIn (state_q.status[rcsf_pkg::STAT_C]),
    .flags   (aluBus.src)
  );

  function automatic logic [7:0] mergeBytes(input logic [7:0] old, input logic [7:0] nw,
                                            input logic en);
    mergeBytes = en ? nw : old;
  endfunction : mergeBytes

  logic access;
  logic wrStrobe;
  logic [7:0] wbyte;
  logic [12:0] pcNext;
  assign access   = wb_cyc_i && wb_stb_i && !state_q.ack;
  assign wrStrobe = access && wb_we_i;
  assign wbyte    = wb_dat_i[7:0];
  assign pcNext   = 13'(pcCurrent + 13'h0001);

  always_comb
  begin
    state_d = state_q;
    state_d.pcLoadValid = 1'b0;
    state_d.pushReturn  = 1'b0;
    state_d.aluStart    = 1'b0;
    state_d.ack         = access;
    state_d.rdata       = 32'h0000_0000;

    // software side first; hardware events below win over same-cycle clears
    if (wrStrobe && wb_sel_i[0])
    begin
      case (wb_adr_i)
        rcsf_pkg::STATUS_ADDR:
          // timeout and power-down stay under hardware control only
          state_d.status[2:0] = wbyte[2:0];
        rcsf_pkg::PWRCTL_ADDR:
          state_d.pwrctl = wbyte & rcsf_pkg::PWRCTL_IMPL;
        rcsf_pkg::IRQST_ADDR:
          state_d.irqStatus = state_q.irqStatus & ~wbyte;
        rcsf_pkg::IRQMASK_ADDR:
          state_d.irqMask = mergeBytes(state_q.irqMask, wbyte, 1'b1);
        rcsf_pkg::CTRL_ADDR:
          state_d.faultEnable = wbyte[0];
        rcsf_pkg::ALU_ADDR:
        begin
          state_d.aluA     = wb_dat_i[7:0];
          state_d.aluB     = mergeBytes(state_q.aluB, wb_dat_i[15:8], wb_sel_i[1]);
          state_d.aluOp    = rcsf_pkg::rcsf_aluop_type'(wb_dat_i[18:16]);
          state_d.aluStart = 1'b1;
        end
        default:
          state_d.aluStart = 1'b0;
      endcase
    end

    if (access && !wb_we_i)
    begin
      case (wb_adr_i)
        rcsf_pkg::STATUS_ADDR:  state_d.rdata = {24'h0, 3'b000, state_q.status[4:0]};
        rcsf_pkg::PWRCTL_ADDR:  state_d.rdata = {24'h0, state_q.pwrctl & rcsf_pkg::PWRCTL_IMPL};
        rcsf_pkg::IRQST_ADDR:   state_d.rdata = {24'h0, state_q.irqStatus};
        rcsf_pkg::IRQMASK_ADDR: state_d.rdata = {24'h0, state_q.irqMask};
        rcsf_pkg::CTRL_ADDR:    state_d.rdata = {31'h0, state_q.faultEnable};
        rcsf_pkg::PC_ADDR:      state_d.rdata = {18'h0, state_q.asleep, state_q.pcLoad};
        rcsf_pkg::ALU_ADDR:     state_d.rdata = {13'h0, state_q.aluOp, state_q.aluB, state_q.aluA};
        rcsf_pkg::ALURES_ADDR:  state_d.rdata = {24'h0, state_q.aluResult};
        default:                state_d.rdata = 32'h0000_0000;
      endcase
    end

    if (aluBus.dst.valid)
    begin
      state_d.aluResult = aluBus.dst.result;
      if (aluBus.dst.setZ)
        state_d.status[rcsf_pkg::STAT_Z] = aluBus.dst.zero;
      if (aluBus.dst.setDc)
        state_d.status[rcsf_pkg::STAT_DC] = aluBus.dst.nibbleCarry;
      if (aluBus.dst.setC)
        state_d.status[rcsf_pkg::STAT_C] = aluBus.dst.carry;
    end

    if (sleepReq && !state_q.asleep)
    begin
      state_d.asleep = 1'b1;
      state_d.status[rcsf_pkg::STAT_TO] = 1'b1;
      state_d.status[rcsf_pkg::STAT_PD] = 1'b0;
    end
    else if (watchdogClear && !state_q.asleep)
    begin
      state_d.status[rcsf_pkg::STAT_TO] = 1'b1;
      state_d.status[rcsf_pkg::STAT_PD] = 1'b1;
    end

    // second half of an interrupt wake: next op ran, now vector
    if (state_q.vectorPending)
    begin
      state_d.vectorPending = 1'b0;
      state_d.pcLoad        = rcsf_pkg::IRQ_VEC;
      state_d.pcLoadValid   = 1'b1;
      state_d.pushReturn    = 1'b1;
    end

    // arithmetic flags left alone by every event except power-on
    case (eventCode)
      rcsf_pkg::EV_POR:
      begin
        state_d.status = rcsf_pkg::STATUS_RST;
        state_d.pwrctl = rcsf_pkg::PWRCTL_POR;
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      rcsf_pkg::EV_BOR:
      begin
        state_d.status[rcsf_pkg::STAT_TO] = 1'b1;
        state_d.status[rcsf_pkg::STAT_PD] = 1'b1;
        state_d.pwrctl[rcsf_pkg::PC_OVF]  = 1'b0;
        state_d.pwrctl[rcsf_pkg::PC_UNF]  = 1'b0;
        state_d.pwrctl[rcsf_pkg::PC_EXT]  = 1'b1;
        state_d.pwrctl[rcsf_pkg::PC_SW]   = 1'b1;
        state_d.pwrctl[rcsf_pkg::PC_BOR]  = 1'b0;
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      rcsf_pkg::EV_WDT:
      begin
        state_d.status[rcsf_pkg::STAT_TO] = 1'b0;
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      rcsf_pkg::EV_WDTWK:
      begin
        state_d.status[rcsf_pkg::STAT_TO] = 1'b0;
        state_d.status[rcsf_pkg::STAT_PD] = 1'b0;
        state_d.pcLoad = pcNext;
      end
      rcsf_pkg::EV_IRQWK:
      begin
        state_d.status[rcsf_pkg::STAT_TO] = 1'b1;
        state_d.status[rcsf_pkg::STAT_PD] = 1'b0;
        state_d.pcLoad = pcNext;
        state_d.vectorPending = globalIrqEnable;
      end
      rcsf_pkg::EV_EXT:
      begin
        state_d.pwrctl[rcsf_pkg::PC_EXT] = 1'b0;
        if (state_q.asleep)
        begin
          state_d.status[rcsf_pkg::STAT_TO] = 1'b1;
          state_d.status[rcsf_pkg::STAT_PD] = 1'b0;
        end
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      rcsf_pkg::EV_SW:
      begin
        state_d.pwrctl[rcsf_pkg::PC_SW] = 1'b0;
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      rcsf_pkg::EV_OVF:
      begin
        state_d.pwrctl[rcsf_pkg::PC_OVF] = 1'b1;
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      rcsf_pkg::EV_UNF:
      begin
        state_d.pwrctl[rcsf_pkg::PC_UNF] = 1'b1;
        state_d.pcLoad = rcsf_pkg::RESET_VEC;
      end
      default:
        state_d.pcLoad = state_d.pcLoad;
    endcase

    if (eventCode != rcsf_pkg::EV_NONE)
    begin
      state_d.pcLoadValid = 1'b1;
      state_d.pushReturn  = 1'b0;
      state_d.asleep      = 1'b0;
      if (eventCode != rcsf_pkg::EV_IRQWK)
        state_d.vectorPending = 1'b0;
      // sticky event bit, set wins over a same-cycle write-one clear
      state_d.irqStatus[3'(eventCode - 4'h1)] = 1'b1;
    end

    state_d.irq = |(state_d.irqStatus & state_d.irqMask);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.status <= rcsf_pkg::STATUS_RST;
      state_q.pwrctl <= rcsf_pkg::PWRCTL_POR;
    end
    else
      state_q <= state_d;
  end

  assign wb_dat_o    = state_q.rdata;
  assign wb_ack_o    = state_q.ack;
  assign pcLoad      = state_q.pcLoad;
  assign pcLoadValid = state_q.pcLoadValid;
  assign pushReturn  = state_q.pushReturn;
  assign asleep      = state_q.asleep;
  assign irq         = state_q.irq;
endmodule : rcsf_reset_cause
`default_nettype wire

// ==== rcsf_reset_cause_checker.sv ====
// checker: port-level properties of the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module rcsf_reset_cause_checker (
  input wire logic        ref_clk,         // core clock
  input wire logic        reset_n,         // async reset
  input wire logic        wb_cyc_i,        // bus cycle
  input wire logic        wb_stb_i,        // bus strobe
  input wire logic        wb_we_i,         // bus write
  input wire logic [7:0]  wb_adr_i,        // bus address
  input wire logic [31:0] wb_dat_o,        // read data
  input wire logic        wb_ack_o,        // acknowledge
  input wire logic        porReq,          // power-on
  input wire logic        borReq,          // brown-out
  input wire logic        wdtReq,          // watchdog
  input wire logic        extReq,          // pin reset
  input wire logic        swReq,           // reset op
  input wire logic        irqWakeReq,      // interrupt wake
  input wire logic        globalIrqEnable, // global enable
  input wire logic [12:0] pcCurrent,       // current pc
  input wire logic [12:0] pcLoad,          // pc to load
  input wire logic        pcLoadValid,     // load pulse
  input wire logic        pushReturn,      // push pulse
  input wire logic        asleep           // sleeping
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  logic hiEv;
  // events that outrank the watchdog and everything below it
  assign hiEv = porReq | borReq | extReq;
  sequence irqWake;
    irqWakeReq && asleep && globalIrqEnable && !hiEv && !wdtReq;
  endsequence
  sequence nextThenVector;
    (pcLoadValid && pcLoad == $past(pcCurrent) + 13'h1) ##1
      (pushReturn && pcLoadValid && pcLoad == rcsf_pkg::IRQ_VEC);
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");
  a_upper_zero: assert property (wb_ack_o && wb_adr_i != rcsf_pkg::ALU_ADDR |->
    wb_dat_o[31:14] == 18'h0)
    else $error("upper read bits not zero");
  a_status_unimpl: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == rcsf_pkg::STATUS_ADDR |-> wb_dat_o[7:5] == 3'h0)
    else $error("unused status bits not zero");
  a_por_restart: assert property (porReq |=>
    pcLoadValid && pcLoad == rcsf_pkg::RESET_VEC && !pushReturn)
    else $error("power-on did not restart at zero");
  a_pin_restart: assert property (extReq && !porReq && !borReq |=>
    pcLoadValid && pcLoad == rcsf_pkg::RESET_VEC)
    else $error("pin reset did not restart at zero");
  a_wdt_run: assert property (wdtReq && !asleep && !hiEv |=>
    pcLoadValid && pcLoad == rcsf_pkg::RESET_VEC)
    else $error("watchdog reset did not restart at zero");
  a_wdt_wake_pc: assert property (wdtReq && asleep && !hiEv |=>
    pcLoadValid && pcLoad == $past(pcCurrent) + 13'h1)
    else $error("watchdog wake did not continue at next pc");
  a_irq_vector: assert property (irqWake |=> nextThenVector)
    else $error("interrupt wake did not vector after next op");
  a_sw_restart: assert property (swReq && !asleep && !hiEv && !wdtReq |=>
    pcLoadValid && pcLoad == rcsf_pkg::RESET_VEC)
    else $error("reset op did not restart at zero");
endmodule : rcsf_reset_cause_checker
bind rcsf_reset_cause rcsf_reset_cause_checker u_checker (.ref_clk, .reset_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .porReq,
  .borReq, .wdtReq, .extReq, .swReq, .irqWakeReq, .globalIrqEnable, .pcCurrent,
  .pcLoad, .pcLoadValid, .pushReturn, .asleep);
`default_nettype wire

// ==== test_rcsf_reset_cause.sv ====
// testbench: register-level walk through every reset and wake cause
`timescale 1ns/1ps
`default_nettype none
module test_rcsf_reset_cause;
  localparam int kPor = 0, kBor = 1, kWdt = 2, kExt = 3, kSw = 4, kOvf = 5, kUnf = 6;
  localparam int kWake = 7, kSleep = 8, kClr = 9;
  logic        ref_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, global_irq_enable;
  logic        pcLoadValid, pushReturn, asleep, irq;
  logic [7:0]  wbAdr;
  logic [31:0] wbDat, wbDatO, q;
  logic [9:0]  ev;
  logic [12:0] pcCur, pcLoad;
  int          badCount, testsRun;
  logic [31:0] aluCmd [7] = '{32'h00010005, 32'h0000010f, 32'h00010503, 32'h00030001,
                              32'h00040040, 32'h00020ff0, 32'h000001ff};
  logic [7:0]  aluRes [7] = '{8'h05, 8'h10, 8'hfe, 8'h00, 8'h81, 8'h00, 8'h00};
  logic [7:0]  aluSt  [7] = '{8'h1b, 8'h1a, 8'h18, 8'h19, 8'h18, 8'h1c, 8'h1f};
  rcsf_reset_cause dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .porReq(ev[kPor]),
    .borReq(ev[kBor]), .wdtReq(ev[kWdt]), .extReq(ev[kExt]), .swReq(ev[kSw]),
    .ovfReq(ev[kOvf]), .unfReq(ev[kUnf]), .irqWakeReq(ev[kWake]),
    .sleepReq(ev[kSleep]), .watchdogClear(ev[kClr]), .globalIrqEnable(global_irq_enable),
    .pcCurrent(pcCur), .pcLoad(pcLoad), .pcLoadValid(pcLoadValid),
    .pushReturn(pushReturn), .asleep(asleep), .irq(irq));
  task automatic results;
    $display("comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= wr;
    wbAdr <= a;
    wbDat <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    if (n >= 20)
    begin
      badCount++;
      results();
    end
  endtask : wbXfer
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wbXfer(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask : rdChk
  // one-cycle pulse; a held level would repeat the event
  task automatic fire(input int k);
    @(posedge ref_clk);
    ev <= 10'h001 << k;
    @(posedge ref_clk);
    ev <= 10'h000;
    @(negedge ref_clk);
  endtask : fire
  task automatic pcChk(input logic v, input logic p, input logic [12:0] pc);
    chk("pcLoad", {17'h0, pcLoadValid, pushReturn, pcLoad}, {17'h0, v, p, pc});
  endtask : pcChk
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    badCount++;
    results();
  end
  initial
  begin
    {reset_n, wbCyc, wbStb, wbWe, global_irq_enable} = 5'h0;
    {wbAdr, wbDat, ev, badCount, testsRun} = '0;
    pcCur = 13'h0123;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h18);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'h0c);
    rdChk("ctrl", rcsf_pkg::CTRL_ADDR, 32'h0);
    rdChk("unmapped", 8'h20, 32'h0);
    wbXfer(1'b1, 8'h20, 32'hff);
    wbXfer(1'b1, rcsf_pkg::STATUS_ADDR, 32'hff);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h1f);
    wbXfer(1'b1, rcsf_pkg::STATUS_ADDR, 32'h00);
    fire(kPor);
    pcChk(1'b1, 1'b0, 13'h0);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h18);
    wbXfer(1'b1, rcsf_pkg::PWRCTL_ADDR, 32'hff);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'hcf);
    fire(kBor);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'h0e);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h18);
    rdChk("irqst", rcsf_pkg::IRQST_ADDR, 32'h03);
    chk("irq", {31'h0, irq}, 32'h0);
    wbXfer(1'b1, rcsf_pkg::IRQMASK_ADDR, 32'h02);
    repeat (2) @(negedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wbXfer(1'b1, rcsf_pkg::IRQST_ADDR, 32'h02);
    repeat (2) @(negedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdChk("irqst", rcsf_pkg::IRQST_ADDR, 32'h01);
    fire(kExt);
    pcChk(1'b1, 1'b0, 13'h0);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'h06);
    fire(kWdt);
    pcChk(1'b1, 1'b0, 13'h0);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h08);
    fire(kSw);
    pcChk(1'b1, 1'b0, 13'h0);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'h02);
    // stack faults must stay silent until the enable is set
    fire(kOvf);
    pcChk(1'b0, 1'b0, 13'h0);
    wbXfer(1'b1, rcsf_pkg::CTRL_ADDR, 32'h01);
    fire(kOvf);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'h82);
    fire(kUnf);
    pcChk(1'b1, 1'b0, 13'h0);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'hc2);
    fire(kSleep);
    chk("asleep", {31'h0, asleep}, 32'h1);
    rdChk("pc", rcsf_pkg::PC_ADDR, 32'h2000);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h10);
    fire(kWdt);
    pcChk(1'b1, 1'b0, 13'h0124);
    chk("asleep", {31'h0, asleep}, 32'h0);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h00);
    fire(kSleep);
    @(posedge ref_clk);
    global_irq_enable <= 1'b1;
    fire(kWake);
    pcChk(1'b1, 1'b0, 13'h0124);
    @(negedge ref_clk);
    pcChk(1'b1, 1'b1, 13'h0004);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h10);
    fire(kSleep);
    wbXfer(1'b1, rcsf_pkg::PWRCTL_ADDR, 32'hff);
    fire(kExt);
    pcChk(1'b1, 1'b0, 13'h0);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h10);
    rdChk("pwrctl", rcsf_pkg::PWRCTL_ADDR, 32'hc7);
    fire(kClr);
    for (int i = 0; i < 7; i++)
    begin
      wbXfer(1'b1, rcsf_pkg::ALU_ADDR, aluCmd[i]);
      rdChk("alu result", rcsf_pkg::ALURES_ADDR, {24'h0, aluRes[i]});
      rdChk("alu flags", rcsf_pkg::STATUS_ADDR, {24'h0, aluSt[i]});
    end
    fire(kSw);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h1f);
    fire(kWdt);
    rdChk("status", rcsf_pkg::STATUS_ADDR, 32'h0f);
    results();
  end
endmodule : test_rcsf_reset_cause
`default_nettype wire
